// *** rtl/eip_ctrl.sv ***
// Extended interrupt enable-two and priority-one registers with request forwarding.
// Assumes the core drives the special-function bus on the system clock and that
// peripheral requests are levels from logic on the same clock.
module eip_ctrl (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic [7:0] req_enable_two_i,
  input wire logic [7:0] req_priority_one_i,
  input wire logic [7:0] ext_enable_one_i,
  input wire logic [7:0] ext_priority_two_i,
  output logic irq_valid_o,
  output logic irq_high_o,
  output logic [3:0] irq_id_o
);

  typedef struct packed {
    logic [7:0] rdata;
    logic irq_valid;
    logic irq_high;
    logic [3:0] irq_id;
  } eip_ctrl_state_t;

  eip_ctrl_state_t state;
  eip_ctrl_state_t next_state;

  logic [7:0] enable_two;
  logic [7:0] priority_one;
  logic wr_enable_two;
  logic wr_priority_one;
  logic [eip_pkg::SRC_COUNT-1:0] pending;
  logic [eip_pkg::SRC_COUNT-1:0] level_high;
  logic [eip_pkg::SRC_COUNT-1:0] req_high;
  logic [eip_pkg::SRC_COUNT-1:0] req_low;
  logic high_valid;
  logic low_valid;
  logic [3:0] high_id;
  logic [3:0] low_id;

  // Address match; the page selector is deliberately not looked at.
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
    addr_hit = (addr == target);
  endfunction

  // Write strobes for the two registers, valid on any register page.
  assign wr_enable_two = sfr_wr_i && addr_hit(sfr_addr_i, eip_pkg::ADDR_ENABLE_TWO);
  assign wr_priority_one = sfr_wr_i && addr_hit(sfr_addr_i, eip_pkg::ADDR_PRIORITY_ONE);

  // The write mask keeps the two unused enable bits at zero.
  eip_sfr_reg #(
    .RESET_VALUE(eip_pkg::ENABLE_TWO_RESET),
    .WRITE_MASK(eip_pkg::ENABLE_TWO_WMASK)
  ) u_enable_two (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .wr_i(wr_enable_two),
    .wdata_i(sfr_wdata_i),
    .q_o(enable_two)
  );

  eip_sfr_reg #(
    .RESET_VALUE(eip_pkg::PRIORITY_ONE_RESET),
    .WRITE_MASK(eip_pkg::PRIORITY_ONE_WMASK)
  ) u_priority_one (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .wr_i(wr_priority_one),
    .wdata_i(sfr_wdata_i),
    .q_o(priority_one)
  );

  // Gating: group A uses our enables, group B the enables held elsewhere.
  // Bits 7 and 5 of enable-two are held at zero, so their requests never pass.
  assign pending = {req_priority_one_i & ext_enable_one_i, req_enable_two_i & enable_two};
  // Levels: group B takes its level from our priority register, group A from outside.
  assign level_high = {priority_one, ext_priority_two_i};
  assign req_high = pending & level_high;
  assign req_low = pending & ~level_high;

  // Two pickers run side by side so the high level never waits on a low scan.
  eip_picker u_pick_high (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .req_i(req_high),
    .valid_o(high_valid),
    .id_o(high_id)
  );

  eip_picker u_pick_low (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .req_i(req_low),
    .valid_o(low_valid),
    .id_o(low_id)
  );

  // Read mux and forwarding choice; an unmapped read returns zero.
  always_comb
  begin
    next_state = state;
    next_state.rdata = eip_pkg::RDATA_IDLE;
    if (sfr_rd_i && addr_hit(sfr_addr_i, eip_pkg::ADDR_ENABLE_TWO))
    begin
      next_state.rdata = enable_two;
    end
    else if (sfr_rd_i && addr_hit(sfr_addr_i, eip_pkg::ADDR_PRIORITY_ONE))
    begin
      next_state.rdata = priority_one;
    end
    next_state.irq_valid = high_valid || low_valid;
    if (high_valid)
    begin
      next_state.irq_high = 1'b1;
      next_state.irq_id = high_id;
    end
    else if (low_valid)
    begin
      next_state.irq_high = 1'b0;
      next_state.irq_id = low_id;
    end
    else
    begin
      next_state.irq_high = 1'b0;
      next_state.irq_id = eip_pkg::ID_IDLE;
    end
  end

  // All outputs come straight from this register.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state.rdata <= eip_pkg::RDATA_IDLE;
      state.irq_valid <= 1'b0;
      state.irq_high <= 1'b0;
      state.irq_id <= eip_pkg::ID_IDLE;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign sfr_rdata_o = state.rdata;
  assign irq_valid_o = state.irq_valid;
  assign irq_high_o = state.irq_high;
  assign irq_id_o = state.irq_id;

  // Helper for the checks: any high-level request pending in this cycle.
  logic any_high_now;
  assign any_high_now = |req_high;

  // Helper for the checks: a bus address that neither register answers to.
  logic rd_unmapped;
  assign rd_unmapped = !addr_hit(sfr_addr_i, eip_pkg::ADDR_ENABLE_TWO)
    && !addr_hit(sfr_addr_i, eip_pkg::ADDR_PRIORITY_ONE);

  // Checks on the gating: a forwarded group-A source had its enable set when sampled.
  a_gate_uart1: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (irq_valid_o && irq_id_o == 4'h6) |-> $past(enable_two[eip_pkg::BIT_UART1_EN], 2))
    else $error("UART1 forwarded while masked.");

  a_gate_adc2_done: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (irq_valid_o && irq_id_o == 4'h4) |-> $past(enable_two[eip_pkg::BIT_ADC2_DONE_EN], 2))
    else $error("ADC2 conversion-done forwarded while masked.");

  a_gate_adc2_win: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (irq_valid_o && irq_id_o == 4'h3) |-> $past(enable_two[eip_pkg::BIT_ADC2_WIN_EN], 2))
    else $error("ADC2 window forwarded while masked.");

  a_gate_timer4: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (irq_valid_o && irq_id_o == 4'h2) |-> $past(enable_two[eip_pkg::BIT_TIMER4_EN], 2))
    else $error("Timer 4 forwarded while masked.");

  a_gate_adc0_done: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (irq_valid_o && irq_id_o == 4'h1) |-> $past(enable_two[eip_pkg::BIT_ADC0_DONE_EN], 2))
    else $error("ADC0 conversion-done forwarded while masked.");

  a_gate_timer3: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (irq_valid_o && irq_id_o == 4'h0) |-> $past(enable_two[eip_pkg::BIT_TIMER3_EN], 2))
    else $error("Timer 3 forwarded while masked.");

  // Unused enable bits read zero even right after a write of all ones.
  a_unused_read_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (sfr_wr_i && sfr_addr_i == eip_pkg::ADDR_ENABLE_TWO) ##1
    (sfr_rd_i && sfr_addr_i == eip_pkg::ADDR_ENABLE_TWO) |=> (sfr_rdata_o[7] == 1'b0 && sfr_rdata_o[5] == 1'b0))
    else $error("Unused enable bit read as one.");

  // A write at the enable address lands and reads back two cycles later.
  a_enable_two_rw: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (sfr_wr_i && sfr_addr_i == eip_pkg::ADDR_ENABLE_TWO) ##1
    (sfr_rd_i && sfr_addr_i == eip_pkg::ADDR_ENABLE_TWO && !sfr_wr_i)
    |=> sfr_rdata_o == ($past(sfr_wdata_i, 2) & eip_pkg::ENABLE_TWO_WMASK))
    else $error("Enable register did not read back its write.");

  // A write at the priority address lands and reads back two cycles later.
  a_priority_rw: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (sfr_wr_i && sfr_addr_i == eip_pkg::ADDR_PRIORITY_ONE) ##1
    (sfr_rd_i && sfr_addr_i == eip_pkg::ADDR_PRIORITY_ONE && !sfr_wr_i)
    |=> sfr_rdata_o == ($past(sfr_wdata_i, 2) & eip_pkg::PRIORITY_ONE_WMASK))
    else $error("Priority register did not read back its write.");

  // Read data stands one cycle only, so a stale byte cannot be mistaken for a fresh read.
  a_rdata_idle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!sfr_rd_i || rd_unmapped) |=> sfr_rdata_o == eip_pkg::RDATA_IDLE)
    else $error("Read data not zero without a mapped read.");

  // Reset brings both registers and the outputs back to their reset values.
  a_reset_values: assert property (@(posedge clk_i)
    !rst_n_i |=> (enable_two == eip_pkg::ENABLE_TWO_RESET && priority_one == eip_pkg::PRIORITY_ONE_RESET
      && !irq_valid_o && sfr_rdata_o == eip_pkg::RDATA_IDLE))
    else $error("State not at reset values after reset.");

  // Group-B levels follow the priority register bits.
  a_level_cmp1_rise: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (irq_valid_o && irq_id_o == 4'hF) |-> irq_high_o == $past(priority_one[eip_pkg::BIT_CMP1_RISE_PRI], 2))
    else $error("Comparator 1 rise at wrong level.");

  a_level_counter: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (irq_valid_o && irq_id_o == 4'hB) |-> irq_high_o == $past(priority_one[eip_pkg::BIT_COUNTER_ARRAY_PRI], 2))
    else $error("Counter array at wrong level.");

  a_level_adc0_win: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (irq_valid_o && irq_id_o == 4'hA) |-> irq_high_o == $past(priority_one[eip_pkg::BIT_ADC0_WIN_PRI], 2))
    else $error("ADC0 window at wrong level.");

  a_level_spi0: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (irq_valid_o && irq_id_o == 4'h8) |-> irq_high_o == $past(priority_one[eip_pkg::BIT_SPI0_PRI], 2))
    else $error("SPI0 at wrong level.");

  a_level_cmp1_fall: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (irq_valid_o && irq_id_o == 4'hE) |-> irq_high_o == $past(priority_one[eip_pkg::BIT_CMP1_FALL_PRI], 2))
    else $error("Comparator 1 fall at wrong level.");

  a_level_cmp0_rise: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (irq_valid_o && irq_id_o == 4'hD) |-> irq_high_o == $past(priority_one[eip_pkg::BIT_CMP0_RISE_PRI], 2))
    else $error("Comparator 0 rise at wrong level.");

  a_level_cmp0_fall: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (irq_valid_o && irq_id_o == 4'hC) |-> irq_high_o == $past(priority_one[eip_pkg::BIT_CMP0_FALL_PRI], 2))
    else $error("Comparator 0 fall at wrong level.");

  a_level_smbus: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (irq_valid_o && irq_id_o == 4'h9) |-> irq_high_o == $past(priority_one[eip_pkg::BIT_SMBUS_PRI], 2))
    else $error("SMBus at wrong level.");

  // A pending high request wins the output two cycles later.
  a_high_first: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    any_high_now |-> ##2 (irq_valid_o && irq_high_o))
    else $error("High-level request not forwarded first.");

  // With only low-level requests pending, one of them goes out at the low level.
  a_low_only: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!any_high_now && |req_low) |-> ##2 (irq_valid_o && !irq_high_o))
    else $error("Low-level request not forwarded at low level.");

  // Nothing pending and enabled: the output falls idle with a zero id.
  a_idle_output: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !(|pending) |-> ##2 (!irq_valid_o && !irq_high_o && irq_id_o == eip_pkg::ID_IDLE))
    else $error("Output not idle with nothing pending.");

  // The two unused enable positions can never be forwarded.
  a_no_unused_id: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    irq_valid_o |-> !(irq_id_o == 4'h7 || irq_id_o == 4'h5))
    else $error("Unused enable position forwarded.");

  // Group-A levels come from outside; one check per source position.
  for (genvar g = 0; g < eip_pkg::GROUP_B_BASE; g++)
  begin : g_level_a
    a_level_group_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (irq_valid_o && irq_id_o == 4'(g)) |-> irq_high_o == $past(ext_priority_two_i[g], 2))
      else $error("Group-A source at wrong level.");
  end

  // Main scenarios.
  c_low_forward: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    irq_valid_o && !irq_high_o);
  c_high_over_low: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    (|req_high && |req_low) ##2 irq_high_o);
  c_enable_write: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_enable_two ##1 (sfr_rd_i && sfr_addr_i == eip_pkg::ADDR_ENABLE_TWO));
  c_priority_write: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_priority_one ##1 (sfr_rd_i && sfr_addr_i == eip_pkg::ADDR_PRIORITY_ONE));
  c_back_to_idle: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    irq_valid_o ##1 !irq_valid_o);

endmodule // eip_ctrl

// *** rtl/eip_pkg.sv ***
// Package of constants for the extended interrupt enable and priority block.
// Assumes an 8-bit special-function-register bus from the CPU core.
package eip_pkg;

  // Register addresses on the special-function bus; both answer on every page.
  localparam logic [7:0] ADDR_ENABLE_TWO = 8'hE7;
  localparam logic [7:0] ADDR_PRIORITY_ONE = 8'hF6;

  // Reset values and writable-bit masks.
  localparam logic [7:0] ENABLE_TWO_RESET = 8'h00;
  localparam logic [7:0] ENABLE_TWO_WMASK = 8'h5F;
  localparam logic [7:0] PRIORITY_ONE_RESET = 8'h00;
  localparam logic [7:0] PRIORITY_ONE_WMASK = 8'hFF;
  localparam logic [7:0] RDATA_IDLE = 8'h00;

  // Field positions in the second extended enable register.
  localparam int BIT_UART1_EN = 6;
  localparam int BIT_ADC2_DONE_EN = 4;
  localparam int BIT_ADC2_WIN_EN = 3;
  localparam int BIT_TIMER4_EN = 2;
  localparam int BIT_ADC0_DONE_EN = 1;
  localparam int BIT_TIMER3_EN = 0;

  // Field positions in the first extended priority register.
  localparam int BIT_CMP1_RISE_PRI = 7;
  localparam int BIT_CMP1_FALL_PRI = 6;
  localparam int BIT_CMP0_RISE_PRI = 5;
  localparam int BIT_CMP0_FALL_PRI = 4;
  localparam int BIT_COUNTER_ARRAY_PRI = 3;
  localparam int BIT_ADC0_WIN_PRI = 2;
  localparam int BIT_SMBUS_PRI = 1;
  localparam int BIT_SPI0_PRI = 0;

  // Source numbering: group A (enable-two sources) at 0..7, group B (priority-one sources) at 8..15.
  localparam int SRC_COUNT = 16;
  localparam int ID_W = 4;
  localparam logic [3:0] GROUP_B_BASE = 4'h8;
  localparam logic [3:0] ID_IDLE = 4'h0;

endpackage

// *** rtl/eip_sfr_reg.sv ***
// One 8-bit special-function register with a writable-bit mask.
// Assumes the write strobe is a one-cycle pulse on the system clock.
module eip_sfr_reg #(
  parameter logic [7:0] RESET_VALUE = 8'h00,
  parameter logic [7:0] WRITE_MASK = 8'hFF
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] q_o
);

  typedef struct packed {
    logic [7:0] val;
  } eip_reg_state_t;

  eip_reg_state_t state;
  eip_reg_state_t next_state;

  // Masked bits never take a one, so they read back as zero for free.
  always_comb
  begin
    next_state = state;
    if (wr_i)
    begin
      next_state.val = wdata_i & WRITE_MASK;
    end
  end

  // Synchronous reset to the documented value.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state.val <= RESET_VALUE & WRITE_MASK;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign q_o = state.val;

endmodule // eip_sfr_reg

// *** rtl/eip_picker.sv ***
// Fixed-order picker: the lowest-numbered active request wins, result registered.
// Assumes requests come from logic on the same clock.
module eip_picker (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [eip_pkg::SRC_COUNT-1:0] req_i,
  output logic valid_o,
  output logic [eip_pkg::ID_W-1:0] id_o
);

  typedef struct packed {
    logic valid;
    logic [eip_pkg::ID_W-1:0] id;
  } eip_pick_state_t;

  eip_pick_state_t state;
  eip_pick_state_t next_state;

  // Scan from the top so the lowest index is the last to overwrite.
  always_comb
  begin
    next_state.valid = |req_i;
    next_state.id = eip_pkg::ID_IDLE;
    for (int i = eip_pkg::SRC_COUNT - 1; i >= 0; i--)
    begin
      if (req_i[i])
      begin
        next_state.id = i[eip_pkg::ID_W-1:0];
      end
    end
  end

  // Synchronous reset clears the pick.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state.valid <= 1'b0;
      state.id <= eip_pkg::ID_IDLE;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign valid_o = state.valid;
  assign id_o = state.id;

endmodule // eip_picker

// *** sim/eip_src_model.sv ***
// Model of the peripheral request sources facing the interrupt block.
// Assumes the bench loads request levels and pulses an acknowledge on the falling edge.
module eip_src_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic load_i,
  input wire logic [7:0] load_a_i,
  input wire logic [7:0] load_b_i,
  input wire logic ack_i,
  input wire logic [3:0] id_i,
  output logic [7:0] req_a_o,
  output logic [7:0] req_b_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // A source drops its level once the core acknowledges it, as a real peripheral flag would.
  always_ff @(negedge clk_i)
  begin
    if (!rst_n_i)
    begin
      req_a_o <= 8'h00;
      req_b_o <= 8'h00;
    end
    else if (load_i)
    begin
      req_a_o <= load_a_i;
      req_b_o <= load_b_i;
    end
    else if (ack_i && id_i[3])
      req_b_o[id_i[2:0]] <= 1'b0;
    else if (ack_i)
      req_a_o[id_i[2:0]] <= 1'b0;
  end
endmodule // eip_src_model

// *** sim/tb_top.sv ***
// Self-checking bench for the extended interrupt enable and priority block.
// Assumes a single 125 MHz clock and that all stimulus changes on the falling edge.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, en1 = 8'h00, pr2 = 8'h00;
  logic wr = 1'b0, rd = 1'b0, ld = 1'b0, ack = 1'b0, valid, high;
  logic [7:0] lda = 8'h00, ldb = 8'h00, reqa, reqb, e2, p1, ra, rb, x, d;
  logic [3:0] id;
  logic [5:0] ex;
  int fail_count = 0, num_checks = 0, seed = 32'h5589, steps, pend;

  // Half period of 4 ns gives the 8 ns system clock.
  always #4 clk_i = ~clk_i;

  eip_ctrl u_eip_ctrl (.clk_i(clk_i), .rst_n_i(rst_n_i), .sfr_addr_i(addr), .sfr_wr_i(wr), .sfr_rd_i(rd),
    .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .req_enable_two_i(reqa), .req_priority_one_i(reqb),
    .ext_enable_one_i(en1), .ext_priority_two_i(pr2), .irq_valid_o(valid), .irq_high_o(high), .irq_id_o(id));
  eip_src_model u_eip_src_model (.clk_i(clk_i), .rst_n_i(rst_n_i), .load_i(ld), .load_a_i(lda),
    .load_b_i(ldb), .ack_i(ack), .id_i(id), .req_a_o(reqa), .req_b_o(reqb));

  // Expected forwarding: high level first, lowest number first within a level, zero when idle.
  function automatic logic [5:0] exp_irq(input logic [7:0] en2, pri1, qa, qb);
    logic [15:0] pnd;
    logic [15:0] lvl;
    logic [5:0] r;
    pnd = {qb & en1, qa & en2 & 8'h5F};
    lvl = {pri1, pr2};
    r = 6'h00;
    for (int i = 15; i >= 0; i--)
      if (pnd[i] && !lvl[i]) r = {2'b10, 4'(i)};
    for (int i = 15; i >= 0; i--)
      if (pnd[i] && lvl[i]) r = {2'b11, 4'(i)};
    return r;
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // Write strobe stands for exactly one rising edge.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk_i);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(negedge clk_i);
    wr <= 1'b0;
  endtask

  // Read data is registered, so it is looked at in the cycle after the read edge.
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(negedge clk_i);
    addr <= a;
    rd <= 1'b1;
    @(negedge clk_i);
    rd <= 1'b0;
    v = rdata;
  endtask

  // Write, then read the same address on the very next edge; the new value must already read back.
  task automatic wr_rd_reg(input logic [7:0] a, input logic [7:0] v, output logic [7:0] r);
    @(negedge clk_i);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(negedge clk_i);
    wr <= 1'b0;
    rd <= 1'b1;
    @(negedge clk_i);
    rd <= 1'b0;
    r = rdata;
  endtask

  task automatic load(input logic [7:0] a, input logic [7:0] b);
    @(negedge clk_i);
    lda <= a;
    ldb <= b;
    ld <= 1'b1;
    @(negedge clk_i);
    ld <= 1'b0;
  endtask

  // Waits out the two-cycle forwarding latency with margin, then compares.
  task automatic irq_chk(input string m);
    repeat (3) @(negedge clk_i);
    ex = exp_irq(e2, p1, ra, rb);
    chk({2'b00, valid, high & valid, id}, {2'b00, ex}, m);
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (5) @(negedge clk_i);
    rst_n_i <= 1'b1;
    rd_reg(eip_pkg::ADDR_ENABLE_TWO, x);
    chk(x, 8'h00, "enable reset");
    rd_reg(eip_pkg::ADDR_PRIORITY_ONE, x);
    chk(x, 8'h00, "priority reset");
    // Random sweep with the all-enabled and all-masked corners first.
    for (int i = 0; i < 150; i++)
    begin
      e2 = 8'($random(seed));
      p1 = 8'($random(seed));
      if (i == 0) e2 = 8'hFF;
      if (i == 1) e2 = 8'h00;
      wr_reg(eip_pkg::ADDR_ENABLE_TWO, e2);
      wr_reg(eip_pkg::ADDR_PRIORITY_ONE, p1);
      rd_reg(eip_pkg::ADDR_ENABLE_TWO, x);
      chk(x, e2 & 8'h5F, "enable readback");
      rd_reg(eip_pkg::ADDR_PRIORITY_ONE, x);
      chk(x, p1, "priority readback");
      wr_rd_reg(eip_pkg::ADDR_ENABLE_TWO, e2 | 8'hA0, x);
      chk(x, e2 & 8'h5F, "enable write then read");
      wr_rd_reg(eip_pkg::ADDR_PRIORITY_ONE, p1, x);
      chk(x, p1, "priority write then read");
      d = 8'($random(seed));
      if (d != eip_pkg::ADDR_ENABLE_TWO && d != eip_pkg::ADDR_PRIORITY_ONE)
      begin
        wr_reg(d, 8'hFF);
        rd_reg(d, x);
        chk(x, 8'h00, "unmapped read");
      end
      e2 = e2 & 8'h5F;
      @(negedge clk_i);
      en1 <= 8'($random(seed));
      pr2 <= 8'($random(seed));
      ra = 8'($random(seed));
      rb = 8'($random(seed));
      load(ra, rb);
      irq_chk("forwarded source");
    end
    // Reset in mid-run: registers and outputs fall back, and the source model clears too.
    @(negedge clk_i);
    rst_n_i <= 1'b0;
    repeat (3) @(negedge clk_i);
    rst_n_i <= 1'b1;
    chk({7'h00, valid}, 8'h00, "idle after reset");
    rd_reg(eip_pkg::ADDR_ENABLE_TWO, x);
    chk(x, 8'h00, "enable after reset");
    rd_reg(eip_pkg::ADDR_PRIORITY_ONE, x);
    chk(x, 8'h00, "priority after reset");
    p1 = 8'h00;
    // Drain every pending source by acknowledging the forwarded one each time.
    wr_reg(eip_pkg::ADDR_ENABLE_TWO, 8'hFF);
    e2 = 8'h5F;
    @(negedge clk_i);
    en1 <= 8'hFF;
    ra = 8'hFF;
    rb = 8'hFF;
    load(ra, rb);
    pend = $countones(ra & 8'h5F) + $countones(rb);
    steps = 0;
    for (int s = 0; s < 20 && (s == 0 || ex[5] === 1'b1); s++)
    begin
      irq_chk("drain order");
      if (ex[5] === 1'b1)
      begin
        steps++;
        if (ex[3]) rb[ex[2:0]] = 1'b0;
        else ra[ex[2:0]] = 1'b0;
        @(negedge clk_i);
        ack <= 1'b1;
        @(negedge clk_i);
        ack <= 1'b0;
      end
    end
    chk(8'(steps), 8'(pend), "drain count");
    chk({7'h00, valid}, 8'h00, "idle after drain");
    end_sim();
  end
endmodule // tb_top
